// *** verilog/software_assisted_serial_shifter.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Function
// - eight-bit shift register and four-bit bit counter between serial lines
// - bytes move most significant bit first
// - each falling serial clock edge except the load edge after a shift register write shifts one bit and counts one
// - after eight pulses count-done output goes low, clocking stops
// - interrupt request on eighth falling edge unless counter was reset
// - interrupt generation disabled after reset
// - shift register write arms interrupt; disable register write disarms
// - shift register write clears counter and enables clocking; reset does not reach the link counter
// - end-of-byte interrupt means data ready or sent; ack on ninth
// - shift register read and written by core at location dd
// - dummy write to disable register at c2 disables the interrupt
// - open-drain selection on output pin connects shifter output
module software_assisted_serial_shifter (
    // core clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // serial link clock domain
    input wire logic ser_clk_in,
    // core data-space access
    input wire logic [7:0] core_addr_in,
    input wire logic core_wr_in,
    input wire logic [7:0] core_wdata_in,
    output logic [7:0] shift_data_reg_out,
    // serial data pins
    input wire logic ser_data_in,
    input wire logic out_open_drain_in,
    output logic ser_data_out,
    output logic ser_data_oe_out,
    // interrupt and status
    output logic irq_n_out,
    output logic count_done_output_out
);
    ////////////////////////////////////////////////////////////////////////////
    // core domain state
    typedef struct packed {
        logic [7:0] load_val;
        logic load_tog;
        logic armed;
        logic irq_n;
        logic [7:0] rd;
        logic done_seen;
        logic sd_o;
        logic sd_oe;
        logic done_o;
    } core_type;
    core_type c_r;
    core_type c_nxt;

    // link domain state
    typedef struct packed {
        logic [7:0] shreg;
        logic [3:0] cnt;
        logic load_ack;
    } link_type;
    link_type l_r;
    link_type l_nxt;

    logic [13:0] link_view;
    logic [7:0] shreg_c;
    logic done_c;
    logic ack_c;
    logic run_c;
    logic [3:0] cnt_c;

    ////////////////////////////////////////////////////////////////////////////
    // crossings
    // the link word stays steady for many core cycles between serial edges
    // and each bit passes four flops before the core takes it
    level_sync #(.WIDTH(14)) u_view_sync (
        .clk_in(sys_clk_in),
        .rst_in(sys_rst_in),
        .async_in({l_r.shreg, l_r.cnt, l_r.load_ack, 1'b1}),
        .sync_out(link_view)
    );

    assign shreg_c = link_view[13:6];
    assign cnt_c = link_view[5:2];
    assign ack_c = link_view[1];
    assign run_c = link_view[0];
    assign done_c = (cnt_c == serial_shifter_pkg::COUNT_FULL);

    ////////////////////////////////////////////////////////////////////////////
    // link logic on falling serial clock edges
    // the core holds load_tog and load_val steady from its write until the
    // next falling serial edge; the serial clock stands still between bytes,
    // so a flop synchroniser on this side would never see the toggle in time
    // hazard: software writes the shift register only while the link idles
    // an unknown acknowledge after power-up falls into the load branch
    always_comb begin
        l_nxt = l_r;
        if (l_r.load_ack == c_r.load_tog) begin
            if (l_r.cnt != serial_shifter_pkg::COUNT_FULL) begin
                // msb leaves first, new bit enters at lsb
                l_nxt.shreg = {l_r.shreg[6:0], ser_data_in};
                l_nxt.cnt = l_r.cnt
                    + serial_shifter_pkg::COUNT_ONE;
            end
        end else begin
            // a pending core write reloads and restarts the byte
            l_nxt.shreg = c_r.load_val;
            l_nxt.cnt = serial_shifter_pkg::COUNT_ZERO;
            l_nxt.load_ack = c_r.load_tog;
        end
    end

    always_ff @(negedge ser_clk_in) begin
        l_r <= l_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // core logic
    always_comb begin
        c_nxt = c_r;
        c_nxt.rd = shreg_c;
        c_nxt.sd_o = shreg_c[7];
        c_nxt.sd_oe = out_open_drain_in & ~shreg_c[7];
        c_nxt.done_o = ~done_c;
        // a byte counts as done only for the load the core asked for last,
        // so a stale done from the previous byte cannot raise the interrupt
        if (done_c && run_c && (ack_c == c_r.load_tog)) begin
            if (!c_r.done_seen && c_r.armed) begin
                c_nxt.irq_n = 1'b0;
            end
            c_nxt.done_seen = 1'b1;
        end else begin
            c_nxt.done_seen = 1'b0;
        end
        // a data write wins over a byte finishing in the same cycle
        if (core_wr_in) begin
            if (core_addr_in == serial_shifter_pkg::ADDR_SHIFT_DATA) begin
                c_nxt.load_val = core_wdata_in;
                c_nxt.load_tog = ~c_r.load_tog;
                c_nxt.armed = 1'b1;
                c_nxt.irq_n = 1'b1;
                c_nxt.done_seen = 1'b0;
            end else if (core_addr_in ==
                         serial_shifter_pkg::ADDR_IRQ_DISABLE) begin
                c_nxt.armed = 1'b0;
                c_nxt.irq_n = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            c_r <= '0;
            c_r.irq_n <= 1'b1;
            c_r.done_o <= 1'b1;
        end else begin
            c_r <= c_nxt;
        end
    end

    assign shift_data_reg_out = c_r.rd;
    assign ser_data_out = c_r.sd_o;
    assign ser_data_oe_out = c_r.sd_oe;
    assign irq_n_out = c_r.irq_n;
    assign count_done_output_out = c_r.done_o;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    // core writes, decoded per target
    sequence s_disable_write;
        core_wr_in && core_addr_in == serial_shifter_pkg::ADDR_IRQ_DISABLE
            && !(core_addr_in == serial_shifter_pkg::ADDR_SHIFT_DATA);
    endsequence

    sequence s_data_write;
        core_wr_in && core_addr_in == serial_shifter_pkg::ADDR_SHIFT_DATA;
    endsequence

    // a write that hits neither register
    sequence s_other_write;
        core_wr_in
            && core_addr_in != serial_shifter_pkg::ADDR_SHIFT_DATA
            && core_addr_in != serial_shifter_pkg::ADDR_IRQ_DISABLE;
    endsequence

    // first cycle of a finished byte while armed and no write lands
    sequence s_irq_due;
        done_c && run_c && ack_c == c_r.load_tog && c_r.armed
            && !c_r.done_seen && !core_wr_in;
    endsequence

    // interrupt low and nothing that would lift it
    sequence s_irq_held;
        !irq_n_out && !(core_wr_in
            && (core_addr_in == serial_shifter_pkg::ADDR_SHIFT_DATA
            || core_addr_in == serial_shifter_pkg::ADDR_IRQ_DISABLE));
    endsequence

    // link: a load is pending at this falling edge
    sequence s_load_edge;
        l_r.load_ack != c_r.load_tog;
    endsequence

    // link: a shifting edge, counter not yet full
    sequence s_shift_edge;
        l_r.cnt < serial_shifter_pkg::COUNT_FULL
            && l_r.load_ack == c_r.load_tog;
    endsequence

    // link: byte complete, no load pending
    sequence s_full_edge;
        l_r.cnt == serial_shifter_pkg::COUNT_FULL
            && l_r.load_ack == c_r.load_tog;
    endsequence

    // core side writes
    chk_disable_quiet: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in) s_disable_write |=> irq_n_out)
        else $error("interrupt active after disable write");

    chk_disable_disarms: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in) s_disable_write |=> !c_r.armed)
        else $error("disable write left interrupt armed");

    chk_other_addr: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        s_other_write |=> c_r.armed == $past(c_r.armed))
        else $error("foreign write changed arming");

    chk_load_toggle: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in) s_data_write |=> c_r.load_tog != $past(c_r.load_tog))
        else $error("data write did not request a load");

    chk_load_value: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in) s_data_write |=> c_r.load_val == $past(core_wdata_in))
        else $error("data write value not held");

    // interrupt
    chk_write_clears_irq: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in) s_data_write |=> irq_n_out && c_r.armed)
        else $error("data write did not rearm");

    chk_irq_needs_arm: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in) $fell(irq_n_out) |-> $past(c_r.armed))
        else $error("interrupt without arming");

    chk_irq_at_done: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in) $fell(irq_n_out) |-> $past(done_c))
        else $error("interrupt before eighth edge");

    chk_irq_fires: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in) s_irq_due |=> !irq_n_out)
        else $error("no interrupt at byte end");

    chk_irq_stays: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in) s_irq_held |=> !irq_n_out)
        else $error("interrupt lifted without a write");

    chk_reset_quiet: assert property (@(posedge sys_clk_in)
        $past(sys_rst_in) |-> irq_n_out && !c_r.armed)
        else $error("interrupt armed after reset");

    // pins and read view
    chk_done_pin: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in) done_c |=> !count_done_output_out)
        else $error("count done output not low");

    chk_done_clear: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in) !done_c |=> count_done_output_out)
        else $error("count done output low while counting");

    chk_oe_msb: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in) ser_data_oe_out |-> !ser_data_out)
        else $error("driving while msb high");

    chk_oe_off: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in) !out_open_drain_in |=> !ser_data_oe_out)
        else $error("driving while not open drain");

    chk_msb_out: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in) 1'b1 |=> ser_data_out == $past(shreg_c[7]))
        else $error("output pin not the msb");

    chk_read_view: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in) 1'b1 |=> shift_data_reg_out == $past(shreg_c))
        else $error("read view not the shifter");

    // link side on falling serial edges
    chk_load_restart: assert property (@(negedge ser_clk_in)
        s_load_edge |=> l_r.cnt == serial_shifter_pkg::COUNT_ZERO
            && l_r.shreg == $past(c_r.load_val))
        else $error("load did not restart the byte");

    chk_count_limit: assert property (@(negedge ser_clk_in)
        s_full_edge |=> $stable(l_r.shreg)
            && l_r.cnt == serial_shifter_pkg::COUNT_FULL)
        else $error("shift after eight pulses");

    chk_count_step: assert property (@(negedge ser_clk_in)
        s_shift_edge
            |=> l_r.cnt == $past(l_r.cnt) + serial_shifter_pkg::COUNT_ONE
            && l_r.shreg[0] == $past(ser_data_in))
        else $error("shift step wrong");

    chk_count_range: assert property (@(negedge ser_clk_in)
        l_r.load_ack == c_r.load_tog |-> l_r.cnt <= serial_shifter_pkg::COUNT_FULL)
        else $error("bit counter beyond eight");
endmodule

// *** verilog/serial_shifter_pkg.sv ***
package serial_shifter_pkg;
    // core data-space locations
    localparam logic [7:0] ADDR_SHIFT_DATA = 8'hDD;
    localparam logic [7:0] ADDR_IRQ_DISABLE = 8'hC2;
    localparam int DATA_W = 8;
    localparam int COUNT_W = 4;
    localparam logic [3:0] COUNT_FULL = 4'h8;
    localparam logic [3:0] COUNT_ZERO = 4'h0;
    localparam logic [3:0] COUNT_ONE = 4'h1;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam int SYNC_LEN = 3;
endpackage

// *** verilog/level_sync.sv ***
`timescale 1ns/10ps
module level_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] val;
    } state_type;
    state_type st_r;
    state_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = async_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.val[i] = st_r.s3[i];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.val;
endmodule

// *** verification/serial_partner.sv ***
`timescale 1ns/10ps
module serial_partner (
    // request from bench
    input wire logic go_in,
    input wire logic [7:0] byte_in,
    output logic done_out,
    // serial lines
    output logic ser_clk_out,
    output logic ser_data_out
);
    integer i;
    initial begin
        ser_clk_out = 1'b1;
        ser_data_out = 1'b1;
        done_out = 1'b0;
        forever begin
            wait (go_in);
            // one load edge, then eight shifting edges
            for (i = 0; i <= 8; i++) begin
                ser_data_out = (i == 0) ? 1'b1 : byte_in[8-i];
                #40 ser_clk_out = 1'b0;
                #80 ser_clk_out = 1'b1;
                #40;
            end
            // released data shows the inverse, clock idles high
            ser_data_out = ~ser_data_out;
            done_out = 1'b1;
            wait (!go_in);
            done_out = 1'b0;
        end
    end
endmodule

// *** verification/tb.sv ***
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, od = 1'b1, go = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, pbyte = 8'h00, rd;
    logic sclk, sdat, done, sout, oe, irq_n, cdone;
    int error_cnt = 0, tests_run = 0;
    always #2 clk = ~clk;
    software_assisted_serial_shifter i_dut (.sys_clk_in(clk),
        .sys_rst_in(rst), .ser_clk_in(sclk), .core_addr_in(addr),
        .core_wr_in(wr), .core_wdata_in(wdata), .shift_data_reg_out(rd),
        .ser_data_in(sdat), .out_open_drain_in(od), .ser_data_out(sout),
        .ser_data_oe_out(oe), .irq_n_out(irq_n),
        .count_done_output_out(cdone));
    serial_partner i_partner (.go_in(go), .byte_in(pbyte),
        .done_out(done), .ser_clk_out(sclk), .ser_data_out(sdat));
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("errors %0d of %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic core_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic frame(input logic [7:0] b);
        int n;
        @(negedge clk);
        pbyte = b;
        go = 1'b1;
        for (n = 0; n < 1000 && !done; n++) @(negedge clk);
        if (!done) begin
            error_cnt++;
            print_verdict();
        end
        go = 1'b0;
        repeat (10) @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check({7'h00, irq_n}, 8'h01);
        check({7'h00, cdone}, 8'h01);
    endtask
    task automatic t_byte();
        core_wr(8'hDD, 8'hA5);
        check({7'h00, irq_n}, 8'h01);
        frame(8'h3C);
        check({7'h00, cdone}, 8'h00);
        check({7'h00, irq_n}, 8'h00);
        check(rd, 8'h3C);
        check({7'h00, oe}, 8'h01);
        check({7'h00, sout}, 8'h00);
        @(negedge clk);
        od = 1'b0;
        repeat (2) @(negedge clk);
        check({7'h00, oe}, 8'h00);
        od = 1'b1;
        frame(8'hFF);
        check(rd, 8'h3C);
        check({7'h00, irq_n}, 8'h00);
    endtask
    task automatic t_disarm();
        core_wr(8'h10, 8'h00);
        check({7'h00, irq_n}, 8'h00);
        core_wr(8'hC2, 8'h5A);
        check({7'h00, irq_n}, 8'h01);
        core_wr(8'hDD, 8'h00);
        core_wr(8'hC2, 8'h00);
        frame(8'h81);
        check(rd, 8'h81);
        check({7'h00, cdone}, 8'h00);
        check({7'h00, irq_n}, 8'h01);
        check({7'h00, sout}, 8'h01);
        check({7'h00, oe}, 8'h00);
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_byte();
        t_disarm();
        print_verdict();
    end
endmodule
